// *** rtl/load_align_regs.vh ***
// Constants for the unaligned word load alignment datapath.
// Assumes inclusion by the datapath, checker and bench modules; definitions only.
`ifndef LOAD_ALIGN_REGS_VH
`define LOAD_ALIGN_REGS_VH
// ==========================================================
// Operation codes
`define OP_NONE       2'h0
`define OP_LEFT       2'h1
`define OP_RIGHT      2'h2
`define OP_ZERO_EXT   2'h3
// ==========================================================
// Access types and offsets
`define ACC_WORD      2'h3
`define LEFT_OFS_LO   3'h0
`define LEFT_OFS_HI   3'h4
`define PADDR_LOW_ZERO 3'h0
`define BYTE_TOP      3'h3
`define LOW_BITS_ZERO 2'h0
`define UPPER_ZERO    32'h0000_0000
// ==========================================================
// State codes
`define ST_IDLE       2'h0
`define ST_WAIT       2'h1
`define ST_DONE       2'h2
`endif

// *** rtl/unaligned_word_load_align.v ***
// Load alignment datapath for left, right and zero-extending word loads.
// Assumes the translation and memory path answer on the same clock with a valid pulse.
`timescale 1ns/10ps
`include "load_align_regs.vh"
module unaligned_word_load_align #(
  parameter AW = 64,
  parameter PW = 36
) (
  input  wire          clock,
  input  wire          srst,
  input  wire          clk_en,
  input  wire          start,
  input  wire [1:0]    op_sel,
  input  wire [63:0]   base_value,
  input  wire [15:0]   offset_imm,
  input  wire [4:0]    dest_reg_field,
  input  wire [63:0]   dest_value,
  input  wire          mode_64,
  input  wire          user_or_super,
  input  wire          cpu_msb_first_flag,
  input  wire          memory_msb_first_flag,
  input  wire          endian_swap_flag,
  output reg  [AW-1:0] vaddr_out,
  output reg  [1:0]    access_type,
  output reg  [2:0]    mem_offset,
  output reg           mem_req,
  input  wire [PW-1:0] paddr_in,
  input  wire          mem_valid,
  input  wire [63:0]   mem_data,
  input  wire          xlate_error,
  input  wire          bus_error,
  output reg  [PW-1:0] paddr_out,
  output reg           wr_en,
  output reg  [4:0]    wr_reg,
  output reg  [63:0]   wr_data,
  output reg           addr_error,
  output reg           reserved_instr,
  output wire          busy
);

  // ==========================================================
  // State and captured operands
  reg [1:0]  state_reg;
  reg [1:0]  op_reg;
  reg [1:0]  byte_reg;
  reg        word_reg;
  reg        m64_reg;
  reg        msbmem_reg;
  reg        swap_reg;
  reg [4:0]  dst_reg;
  reg [63:0] old_reg;
  reg [63:0] data_reg;
  reg [4:0]  last_dst_reg;
  reg [63:0] last_val_reg;
  reg        last_ok_reg;

  // ==========================================================
  // Address forming
  wire [63:0] sext_ofs;
  wire [63:0] vaddr;
  wire [1:0]  byte_idx;
  wire        word_sel;
  wire        take;
  wire        zext_sel;
  wire        zext_reserved;
  wire        zext_misaligned;
  wire        issue;
  wire        refuse;
  wire        in_wait;
  wire        in_done;
  wire        fault;
  wire        answer_ok;
  wire [63:0] old_value;

  assign sext_ofs        = {{48{offset_imm[15]}}, offset_imm};
  assign vaddr           = base_value + sext_ofs;
  assign byte_idx        = vaddr[1:0] ^ {2{cpu_msb_first_flag}};
  assign word_sel        = vaddr[2] ^ cpu_msb_first_flag;
  assign take            = clk_en && start && (op_sel != `OP_NONE) && (state_reg == `ST_IDLE);
  assign zext_sel        = (op_sel == `OP_ZERO_EXT);
  assign zext_reserved   = zext_sel && !mode_64 && user_or_super;
  assign zext_misaligned = zext_sel && (vaddr[1:0] != `LOW_BITS_ZERO);
  // Partial loads have no alignment check at all
  assign issue           = take && !zext_reserved && !zext_misaligned;
  assign refuse          = take && (zext_reserved || zext_misaligned);
  assign in_wait         = (state_reg == `ST_WAIT);
  assign in_done         = (state_reg == `ST_DONE);
  assign fault           = in_wait && (xlate_error || bus_error);
  assign answer_ok       = in_wait && mem_valid && !xlate_error && !bus_error;
  assign busy            = (state_reg != `ST_IDLE);

  // Forward the value just written when the same register is the target again
  assign old_value = (last_ok_reg && last_dst_reg == dest_reg_field) ?
                     last_val_reg : dest_value;

  // ==========================================================
  // Byte merge, one lane per byte of the low register word
  wire [31:0] mem_word;
  wire [31:0] merged;
  reg  [63:0] result;

  // The answer word is captured with its valid pulse; the bus data is gone a cycle later
  assign mem_word = word_reg ? data_reg[63:32] : data_reg[31:0];

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      localparam [2:0] LANE = lane;
      wire [2:0] src_sum;
      wire [2:0] left_sum;
      wire [7:0] right_byte;
      wire [7:0] left_byte;
      wire [7:0] keep_byte;
      wire       right_hit;
      wire       left_hit;

      assign src_sum    = {1'b0, byte_reg} + LANE;
      assign left_sum   = src_sum - `BYTE_TOP;
      // Right: start byte lands low and lanes past the word top keep old contents
      assign right_hit  = (src_sum <= `BYTE_TOP);
      // Left: start byte lands in the top lane and lanes down to the one holding memory byte 0 take memory bytes
      assign left_hit   = (src_sum >= `BYTE_TOP);
      assign right_byte = mem_word[{src_sum[1:0], 3'h0} +: 8];
      assign left_byte  = mem_word[{left_sum[1:0], 3'h0} +: 8];
      assign keep_byte  = old_reg[8*lane +: 8];
      assign merged[8*lane +: 8] = (op_reg == `OP_RIGHT) ?
                                   (right_hit ? right_byte : keep_byte) :
                                   (left_hit ? left_byte : keep_byte);
    end
  endgenerate

  always @* begin
    result = old_reg;
    if (op_reg == `OP_ZERO_EXT) begin
      result = {`UPPER_ZERO, mem_word};
    end else if (m64_reg) begin
      result = {{32{merged[31]}}, merged};
    end else begin
      // 32-bit mode keeps the upper half as it was
      result = {old_reg[63:32], merged};
    end
  end

  // ==========================================================
  // Sequencer
  always @(posedge clock) begin
    if (srst) begin
      state_reg <= `ST_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        `ST_IDLE: begin
          if (issue) begin
            state_reg <= `ST_WAIT;
          end
        end
        `ST_WAIT: begin
          if (xlate_error || bus_error) begin
            state_reg <= `ST_IDLE;
          end else if (mem_valid) begin
            state_reg <= `ST_DONE;
          end
        end
        `ST_DONE: begin
          state_reg <= `ST_IDLE;
        end
        default: begin
          state_reg <= `ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Operand capture at the take edge
  always @(posedge clock) begin
    if (srst) begin
      op_reg     <= `OP_NONE;
      byte_reg   <= 2'h0;
      word_reg   <= 1'b0;
      m64_reg    <= 1'b0;
      msbmem_reg <= 1'b0;
      swap_reg   <= 1'b0;
      dst_reg    <= 5'h00;
      old_reg    <= 64'h0;
    end else if (take) begin
      op_reg     <= op_sel;
      byte_reg   <= byte_idx;
      word_reg   <= word_sel;
      m64_reg    <= mode_64;
      msbmem_reg <= memory_msb_first_flag;
      swap_reg   <= endian_swap_flag;
      dst_reg    <= dest_reg_field;
      old_reg    <= old_value;
    end
  end

  // ==========================================================
  // Memory request
  always @(posedge clock) begin
    if (srst) begin
      vaddr_out   <= {AW{1'b0}};
      access_type <= 2'h0;
      mem_offset  <= 3'h0;
      mem_req     <= 1'b0;
    end else if (clk_en) begin
      mem_req <= issue;
      if (take) begin
        vaddr_out <= vaddr[AW-1:0];
      end
      if (issue) begin
        if (op_sel == `OP_ZERO_EXT) begin
          access_type <= `ACC_WORD;
          mem_offset  <= vaddr[2:0];
        end else if (op_sel == `OP_RIGHT) begin
          access_type <= vaddr[1:0];
          mem_offset  <= vaddr[2:0];
        end else begin
          access_type <= vaddr[1:0];
          mem_offset  <= vaddr[2] ? `LEFT_OFS_HI : `LEFT_OFS_LO;
        end
      end
    end
  end

  // ==========================================================
  // Refusal flags
  always @(posedge clock) begin
    if (srst) begin
      addr_error     <= 1'b0;
      reserved_instr <= 1'b0;
    end else if (clk_en) begin
      addr_error     <= take && !zext_reserved && zext_misaligned;
      reserved_instr <= take && zext_reserved;
    end
  end

  // ==========================================================
  // Answer capture and physical address adjust
  always @(posedge clock) begin
    if (srst) begin
      data_reg  <= 64'h0;
      paddr_out <= {PW{1'b0}};
    end else if (clk_en && answer_ok) begin
      data_reg <= mem_data;
      if (op_reg == `OP_ZERO_EXT) begin
        paddr_out <= {paddr_in[PW-1:3], paddr_in[2] ^ swap_reg, paddr_in[1:0]};
      end else if (msbmem_reg) begin
        paddr_out <= {paddr_in[PW-1:3], `PADDR_LOW_ZERO};
      end else begin
        paddr_out <= {paddr_in[PW-1:3], paddr_in[2:0] ^ {3{swap_reg}}};
      end
    end
  end

  // ==========================================================
  // Writeback
  always @(posedge clock) begin
    if (srst) begin
      wr_en   <= 1'b0;
      wr_reg  <= 5'h00;
      wr_data <= 64'h0;
    end else if (clk_en) begin
      // Only a completed answer reaches this state, so faults never write
      wr_en <= in_done;
      if (in_done) begin
        wr_reg  <= dst_reg;
        wr_data <= result;
      end
    end
  end

  // ==========================================================
  // Forwarding store
  always @(posedge clock) begin
    if (srst) begin
      last_dst_reg <= 5'h00;
      last_val_reg <= 64'h0;
      last_ok_reg  <= 1'b0;
    end else if (clk_en) begin
      if (in_done) begin
        last_dst_reg <= dst_reg;
        last_val_reg <= result;
        last_ok_reg  <= 1'b1;
      end else if (refuse || fault) begin
        // A load that wrote nothing leaves nothing to forward
        last_ok_reg <= 1'b0;
      end
    end
  end

endmodule // unaligned_word_load_align

// *** verif/load_align_properties.sv ***
// Port-level checks for the load alignment datapath.
// Assumes one clock domain; bound onto the datapath module.
`timescale 1ns/10ps
`include "load_align_regs.vh"
module load_align_properties #(parameter AW = 64, parameter PW = 36) (
  input wire logic          clock, srst, clk_en, start, busy, mode_64, user_or_super,
  input wire logic          cpu_msb_first_flag, memory_msb_first_flag, mem_req, mem_valid,
  input wire logic          xlate_error, bus_error, wr_en, addr_error, reserved_instr,
  input wire logic [1:0]    op_sel, access_type,
  input wire logic [2:0]    mem_offset,
  input wire logic [15:0]   offset_imm,
  input wire logic [63:0]   base_value,
  input wire logic [AW-1:0] vaddr_out,
  input wire logic [PW-1:0] paddr_in, paddr_out
);
  // ==========================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire tk = clk_en && start && !busy;
  wire le = !cpu_msb_first_flag && !memory_msb_first_flag;
  a_right_addr: assert property (tk && op_sel == `OP_RIGHT |=> vaddr_out ==
    $past(base_value) + {{48{$past(offset_imm[15])}}, $past(offset_imm)})
    else $error("right load address wrong");
  a_right_type: assert property (tk && op_sel == `OP_RIGHT && le |=> mem_req &&
    access_type == vaddr_out[1:0] && mem_offset == vaddr_out[2:0])
    else $error("right load type or offset wrong");
  a_left_type: assert property (tk && op_sel == `OP_LEFT && le |=> mem_req &&
    access_type == vaddr_out[1:0] && mem_offset == {vaddr_out[2], 2'h0})
    else $error("left load type or offset wrong");
  a_right_no_err: assert property (tk && op_sel == `OP_RIGHT |=> !addr_error [*2])
    else $error("right load raised address error");
  a_zext_misalign: assert property (tk && op_sel == `OP_ZERO_EXT && mode_64 &&
    (base_value[1:0] + offset_imm[1:0] != 2'h0) |=> addr_error && !mem_req)
    else $error("misaligned word load not refused");
  a_zext_reserved: assert property (tk && op_sel == `OP_ZERO_EXT && !mode_64 &&
    user_or_super |=> reserved_instr && !mem_req) else $error("reserved load not flagged");
  a_fault_no_write: assert property (busy && (xlate_error || bus_error) |=> !wr_en [*3])
    else $error("write after fault");
  a_paddr_write: assert property (busy && mem_valid |=>
    paddr_out[PW-1:3] == $past(paddr_in[PW-1:3]) ##1 wr_en) else $error("paddr or write late");
endmodule // load_align_properties
bind unaligned_word_load_align load_align_properties #(.AW(AW), .PW(PW)) chk_u (.clock,
  .srst, .clk_en, .start, .busy, .mode_64, .user_or_super, .cpu_msb_first_flag,
  .memory_msb_first_flag, .mem_req, .mem_valid, .xlate_error, .bus_error, .wr_en,
  .addr_error, .reserved_instr, .op_sel, .access_type, .mem_offset, .offset_imm,
  .base_value, .vaddr_out, .paddr_in, .paddr_out);

// *** verif/mem_path_model.sv ***
// Far-side model of translation and memory load path.
// Assumes the datapath clock; lat adds wait cycles, flt picks a fault kind.
`timescale 1ns/10ps
module mem_path_model #(parameter [63:0] MD = 64'h0) (
  input  wire        clock, srst, mem_req,
  input  wire [63:0] vaddr_out,
  input  wire [1:0]  lat, flt,
  output reg         mem_valid, xlate_error, bus_error,
  output reg  [63:0] mem_data,
  output reg  [35:0] paddr_in
);
  reg       pend;
  reg [1:0] cnt;
  // ==========================================================
  // Answer; idle lines invert each cycle so stale data never matches
  always @(posedge clock) begin
    {mem_valid, xlate_error, bus_error} <= 3'h0;
    mem_data <= ~mem_data;
    paddr_in <= ~paddr_in;
    if (srst) begin
      pend <= 1'b0;
      mem_data <= 64'h0;
      paddr_in <= 36'h0;
    end else if (mem_req) begin
      pend <= 1'b1;
      cnt <= lat;
    end else if (pend && cnt != 2'h0) cnt <= cnt - 2'h1;
    else if (pend) begin
      pend <= 1'b0;
      {mem_valid, xlate_error, bus_error} <= {flt == 2'h0, flt == 2'h1, flt == 2'h2};
      mem_data <= MD;
      paddr_in <= vaddr_out[35:0] + 36'h100000000;
    end
  end
endmodule // mem_path_model

// *** verif/unaligned_word_load_align_tb_top.sv ***
// Self-checking bench for the load alignment datapath.
// Assumes the far-side model and bound checker; inputs move at the falling edge.
`timescale 1ns/10ps
`include "load_align_regs.vh"
module unaligned_word_load_align_tb_top;
  localparam [63:0] MD = 64'hf1e2d3c4_b5a69788;
  localparam [63:0] DV = 64'h01234567_89abcdef;
  logic        clock = 0, srst = 1, start = 0, cf = 0, mf = 0, sf = 0, m64 = 1, us = 0, ce = 1;
  logic [1:0]  op_sel = 0, lat = 0, flt = 0, access_type;
  logic [15:0] offset_imm = 0;
  logic [4:0]  dest_reg_field = 0, lr = 0, gr, wr_reg;
  logic [63:0] lv = 0, got, vaddr_out, mem_data, wr_data;
  logic [35:0] paddr_in, paddr_out;
  logic [2:0]  mem_offset;
  logic        mem_req, mem_valid, xlate_error, bus_error, wr_en, addr_error, reserved_instr, busy;
  integer      failures = 0, checks = 0, i;
  always #20 clock = ~clock;
  unaligned_word_load_align dut_u (.clock, .srst, .clk_en(ce), .start, .op_sel,
    .base_value(64'h1010), .offset_imm, .dest_reg_field, .dest_value(DV), .mode_64(m64),
    .user_or_super(us), .cpu_msb_first_flag(cf), .memory_msb_first_flag(mf),
    .endian_swap_flag(sf), .vaddr_out, .access_type, .mem_offset, .mem_req, .paddr_in,
    .mem_valid, .mem_data, .xlate_error, .bus_error, .paddr_out, .wr_en, .wr_reg, .wr_data,
    .addr_error, .reserved_instr, .busy);
  mem_path_model #(.MD(MD)) model_u (.clock, .srst, .mem_req, .vaddr_out, .lat, .flt,
    .mem_valid, .xlate_error, .bus_error, .mem_data, .paddr_in);
  // ==========================================================
  // Tasks
  task close_out;
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string s, input logic [63:0] x, input logic [63:0] y);
    checks++;
    if (y !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, x, y);
    end
  endtask
  function automatic logic [63:0] ex(input logic [1:0] o, input logic [63:0] va, g);
    logic [1:0] b;
    logic [31:0] w, t;
    b = va[1:0] ^ {2{cf}};
    w = (va[2] ^ cf) ? MD[63:32] : MD[31:0];
    if (o == `OP_ZERO_EXT) return {32'h0, w};
    if (o == `OP_RIGHT) t = (w >> 8*b) | (g[31:0] & ~(32'hffffffff >> 8*b));
    else t = (w << 8*(2'd3 - b)) | (g[31:0] & ~(32'hffffffff << 8*(2'd3 - b)));
    return m64 ? {{32{t[31]}}, t} : {g[63:32], t};
  endfunction
  // Forwarded value is tracked here since dest_value stays stale on purpose
  task go(input logic [1:0] o, input logic [4:0] n, r);
    logic [63:0] va, e;
    logic [35:0] pa;
    logic w, ae, ri, sw, se, sr;
    begin
      va = 64'h1000 + n;
      pa = va[35:0] + 36'h100000000;
      e = ex(o, va, (r == lr) ? lv : DV);
      ae = (o == `OP_ZERO_EXT) && m64 && (va[1:0] != 2'h0);
      ri = (o == `OP_ZERO_EXT) && !m64 && us;
      w = !ae && !ri && flt == 2'h0;
      {sw, se, sr} = 3'h0;
      @(negedge clock);
      {start, op_sel, offset_imm, dest_reg_field} = {1'b1, o, 16'hfff0 + n, r};
      @(negedge clock);
      start = 0;
      for (int k = 0; k < 20; k++) begin
        if (wr_en === 1'b1) {sw, got, gr} = {1'b1, wr_data, wr_reg};
        se |= addr_error === 1'b1;
        sr |= reserved_instr === 1'b1;
        if (k > 2 && busy === 1'b0) break;
        @(negedge clock);
      end
      chk("write", w, sw);
      chk("addr_error", ae, se);
      chk("reserved", ri, sr);
      if (w) chk("wr_data", e, got);
      if (w) chk("wr_reg", r, gr);
      if (w) {lr, lv} = {r, e};
      if (w && o != `OP_ZERO_EXT) chk("paddr", {pa[35:3], mf ? 3'h0 : pa[2:0] ^ {3{sf}}}, paddr_out);
      if (!ae && !ri && !cf && !mf) begin
        chk("vaddr", va, vaddr_out);
        chk("type", o == `OP_ZERO_EXT ? `ACC_WORD : va[1:0], access_type);
        chk("offset", o == `OP_LEFT ? {va[2], 2'h0} : va[2:0], mem_offset);
      end
    end
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    srst = 0;
    for (i = 0; i < 16; i++) begin
      {m64, lat} = {i[0], i[1:0]};
      go(i < 8 ? `OP_RIGHT : `OP_LEFT, i[2:0], i + 1);
    end
    m64 = 1;
    go(`OP_RIGHT, 5, 20);
    go(`OP_LEFT, 8, 20);
    go(`OP_ZERO_EXT, 4, 21);
    go(`OP_ZERO_EXT, 6, 22);
    {m64, us} = 2'h1;
    go(`OP_ZERO_EXT, 4, 23);
    us = 0;
    go(`OP_ZERO_EXT, 0, 24);
    for (i = 1; i < 3; i++) begin
      flt = i;
      go(`OP_RIGHT, 2, 20);
    end
    {flt, m64, cf, sf} = 5'h7;
    go(`OP_RIGHT, 1, 25);
    {cf, mf} = 2'h1;
    go(`OP_LEFT, 6, 26);
    @(negedge clock);
    {ce, start, op_sel} = {2'b01, `OP_RIGHT};
    @(negedge clock);
    {ce, start} = 2'b10;
    chk("frozen", 64'h0, {busy, mem_req, addr_error});
    close_out;
  end
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule // unaligned_word_load_align_tb_top
